/* File: src/lgl_params.svh */
// Purpose: constants for the led grayscale latch control core
// Assumes: included by bare name wherever needed
// Notes: register offsets are byte addresses on the axi4-lite bus
`ifndef LGL_PARAMS_SVH
`define LGL_PARAMS_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define LGL_OFS_STATUS 8'h00
`define LGL_OFS_MASK 8'h04
`define LGL_OFS_CTRL 8'h08
`define LGL_OFS_INFO 8'h0C
`define LGL_OFS_BRIGHT 8'h10
`define LGL_OFS_COUNT 8'h14

// ****************************************************************
// field positions
// ****************************************************************
`define LGL_EV_GS_LATCH 0
`define LGL_EV_CTRL_LATCH 1
`define LGL_EV_REF_SHORT 2
`define LGL_EV_WRAP 3
`define LGL_CTRL_SW_BLANK 0
`define LGL_INFO_REF_SHORT 0
`define LGL_SR_SELECT 192
`define LGL_SR_TIMING_RESET_BIT 7
`define LGL_BRIGHT_TIMING_RESET_BIT 8
`define LGL_BRIGHT_FIRST_LSB 16

// ****************************************************************
// sizes and reset values
// ****************************************************************
`define LGL_SR_BITS 193
`define LGL_GS_BITS 192
`define LGL_CHANNELS 16
`define LGL_EV_BITS 4
`define LGL_CNT_RESET 12'h000
`define LGL_CNT_LAST 12'hFFF
`define LGL_EV_RESET 4'h0
`define LGL_BRIGHT_RESET 7'h00
`define LGL_RESP_OKAY 2'b00
`define LGL_RESP_SLVERR 2'b10

`endif

/* File: src/lgl_pkg.sv */
// Purpose: shared types of the led grayscale latch control core
// Assumes: nothing
// Notes: constants live in lgl_params.svh
package lgl_pkg;

	// ****************************************************************
	// pin bundle
	// ****************************************************************
	typedef struct packed {
		logic serial_in;
		logic shift_clock;
		logic latch_strobe;
		logic pwm_ref_clock;
		logic output_blank;
		logic ref_short;
	} lgl_pins_t;

	// ****************************************************************
	// control latch contents
	// ****************************************************************
	typedef struct packed {
		logic timing_reset_bit;
		logic [6:0] global_brightness;
	} lgl_ctrl_t;

	typedef enum logic [0:0] {
		LGL_ST_IDLE,
		LGL_ST_RESP
	} lgl_bus_st_t;

endpackage

/* File: src/lgl_sync.sv */
// Purpose: two-flop synchroniser for the pin bundle
// Assumes: pins are asynchronous to aclk
// Notes: first stage feeds only the second stage
`timescale 1ns/1ns
module lgl_sync
	import lgl_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire lgl_pins_t pins_in,
	output lgl_pins_t pins_out
);

	lgl_pins_t meta_q;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			meta_q <= '0;
			pins_out <= '0;
		end
		else if (ce)
		begin
			meta_q <= pins_in;
			pins_out <= meta_q;
		end
	end

endmodule

/* File: src/lgl_top.sv */
// Purpose: latch, grayscale counter and pwm outputs of a 16-channel led sink driver
// Assumes: pins are asynchronous and much slower than aclk
// Notes: registers on axi4-lite
// ****************************************************************
// ****************************************************************
`timescale 1ns/1ns
`include "lgl_params.svh"
module lgl_top
	import lgl_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic serial_in,
	input wire logic shift_clock,
	input wire logic latch_strobe,
	input wire logic pwm_ref_clock,
	input wire logic output_blank,
	input wire logic ref_current_short,
	output logic serial_out,
	output logic [15:0] sink_output,
	output logic irq
);

	// ****************************************************************
	// functions
	// ****************************************************************
	function automatic logic [11:0] gs_of(input logic [191:0] v, input int ch);
		gs_of = v[ch*12 +: 12];
	endfunction

	function automatic logic [31:0] strb_mask(input logic [3:0] s);
		strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
	endfunction

	function automatic logic known_ofs(input logic [7:0] a);
		known_ofs = (a == `LGL_OFS_STATUS) || (a == `LGL_OFS_MASK) ||
			(a == `LGL_OFS_CTRL) || (a == `LGL_OFS_INFO) ||
			(a == `LGL_OFS_BRIGHT) || (a == `LGL_OFS_COUNT);
	endfunction

	// ****************************************************************
	// pin synchronisers and edges
	// ****************************************************************
	lgl_pins_t pins_raw;
	lgl_pins_t pins_s;
	lgl_pins_t pins_prev_q;
	logic shift_rise;
	logic latch_rise;
	logic pwm_rise;
	logic short_rise;

	assign pins_raw = '{serial_in: serial_in, shift_clock: shift_clock,
		latch_strobe: latch_strobe, pwm_ref_clock: pwm_ref_clock,
		output_blank: output_blank, ref_short: ref_current_short};

	lgl_sync u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.pins_in(pins_raw),
		.pins_out(pins_s)
	);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			pins_prev_q <= '0;
		else if (ce)
			pins_prev_q <= pins_s;
	end

	assign shift_rise = pins_s.shift_clock && !pins_prev_q.shift_clock;
	assign latch_rise = pins_s.latch_strobe && !pins_prev_q.latch_strobe;
	assign pwm_rise = pins_s.pwm_ref_clock && !pins_prev_q.pwm_ref_clock;
	assign short_rise = pins_s.ref_short && !pins_prev_q.ref_short;

	// ****************************************************************
	// shift register
	// ****************************************************************
	logic [192:0] shift_q;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			shift_q <= '0;
		else if (ce && shift_rise)
			shift_q <= {shift_q[191:0], pins_s.serial_in};
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			serial_out <= 1'b0;
		else if (ce)
			serial_out <= shift_q[`LGL_SR_SELECT];
	end

	// ****************************************************************
	// latches
	// ****************************************************************
	logic [191:0] gs1_q;
	logic [191:0] gs2_q;
	lgl_ctrl_t ctrl1_q;
	logic [6:0] bright2_q;
	logic gs_event;
	logic ctrl_event;
	logic tmg_event;
	logic [11:0] cnt_q;
	logic sw_blank_q;
	logic blank;
	logic wrap;

	assign gs_event = latch_rise && !shift_q[`LGL_SR_SELECT];
	assign ctrl_event = latch_rise && shift_q[`LGL_SR_SELECT];
	assign tmg_event = gs_event && ctrl1_q.timing_reset_bit;
	assign blank = pins_s.output_blank || sw_blank_q;
	assign wrap = !blank && pwm_rise && (cnt_q == `LGL_CNT_LAST);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			gs1_q <= '0;
		else if (ce && gs_event)
			gs1_q <= shift_q[191:0];
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			ctrl1_q <= '0;
		else if (ce && ctrl_event)
			ctrl1_q <= shift_q[`LGL_SR_TIMING_RESET_BIT:0];
	end

	// second latch takes the first at the end of each display period, or the shift register on a timing-reset grayscale latch
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			gs2_q <= '0;
		else if (ce && tmg_event)
			gs2_q <= shift_q[191:0];
		else if (ce && wrap)
			gs2_q <= gs1_q;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			bright2_q <= `LGL_BRIGHT_RESET;
		else if (ce && tmg_event)
			bright2_q <= ctrl1_q.global_brightness;
	end

	// ****************************************************************
	// grayscale counter and outputs
	// ****************************************************************
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			cnt_q <= `LGL_CNT_RESET;
		else if (ce)
		begin
			if (blank)
				cnt_q <= `LGL_CNT_RESET;
			else if (tmg_event)
				cnt_q <= `LGL_CNT_RESET;
			else if (pwm_rise)
				cnt_q <= cnt_q + 12'h001;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			sink_output <= '0;
		else if (ce)
		begin
			for (int ch = 0; ch < `LGL_CHANNELS; ch++)
			begin
				if (blank)
					sink_output[ch] <= 1'b0;
				else if (pins_s.ref_short)
					sink_output[ch] <= 1'b0;
				else
					sink_output[ch] <= cnt_q < gs_of(gs2_q, ch);
			end
		end
	end

	// ****************************************************************
	// bus slave
	// ****************************************************************
	logic aw_hold_q;
	logic w_hold_q;
	logic [7:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic wr_commit;
	logic [31:0] wmask;
	logic [31:0] rdata_d;
	logic [3:0] status_q;
	logic [3:0] mask_q;
	logic [3:0] ev_set;
	logic [3:0] ev_clr;
	lgl_bus_st_t wr_st_q;

	assign wr_commit = aw_hold_q && w_hold_q && (wr_st_q == LGL_ST_IDLE);
	assign wmask = wdata_q & strb_mask(wstrb_q);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_hold_q <= 1'b0;
			awaddr_q <= '0;
			s_axi_awready <= 1'b0;
		end
		else if (ce)
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_hold_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			else if (wr_commit)
				aw_hold_q <= 1'b0;
			else if (!aw_hold_q && wr_st_q == LGL_ST_IDLE)
				s_axi_awready <= 1'b1;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			w_hold_q <= 1'b0;
			wdata_q <= '0;
			wstrb_q <= '0;
			s_axi_wready <= 1'b0;
		end
		else if (ce)
		begin
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_hold_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			else if (wr_commit)
				w_hold_q <= 1'b0;
			else if (!w_hold_q && wr_st_q == LGL_ST_IDLE)
				s_axi_wready <= 1'b1;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			wr_st_q <= LGL_ST_IDLE;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `LGL_RESP_OKAY;
		end
		else if (ce)
		begin
			case (wr_st_q)
				LGL_ST_IDLE:
				begin
					if (wr_commit)
					begin
						wr_st_q <= LGL_ST_RESP;
						s_axi_bvalid <= 1'b1;
						s_axi_bresp <= known_ofs(awaddr_q) ? `LGL_RESP_OKAY : `LGL_RESP_SLVERR;
					end
				end
				LGL_ST_RESP:
				begin
					if (s_axi_bready)
					begin
						wr_st_q <= LGL_ST_IDLE;
						s_axi_bvalid <= 1'b0;
					end
				end
				default:
					wr_st_q <= LGL_ST_IDLE;
			endcase
		end
	end

	// ****************************************************************
	// control, mask and status registers
	// ****************************************************************
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			sw_blank_q <= 1'b0;
			mask_q <= `LGL_EV_RESET;
		end
		else if (ce && wr_commit)
		begin
			if (awaddr_q == `LGL_OFS_CTRL && wstrb_q[0])
				sw_blank_q <= wdata_q[`LGL_CTRL_SW_BLANK];
			if (awaddr_q == `LGL_OFS_MASK && wstrb_q[0])
				mask_q <= wdata_q[3:0];
		end
	end

	assign ev_set = {wrap, short_rise, ctrl_event, gs_event};
	assign ev_clr = (wr_commit && awaddr_q == `LGL_OFS_STATUS) ? wmask[3:0] : 4'h0;

	// set beats a clear in the same cycle
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			status_q <= `LGL_EV_RESET;
		else if (ce)
			status_q <= (status_q & ~ev_clr) | ev_set;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			irq <= 1'b0;
		else if (ce)
			irq <= |(status_q & mask_q);
	end

	// ****************************************************************
	// read channel
	// ****************************************************************
	always_comb
	begin
		rdata_d = 32'h0000_0000;
		case (s_axi_araddr)
			`LGL_OFS_STATUS: rdata_d[3:0] = status_q;
			`LGL_OFS_MASK: rdata_d[3:0] = mask_q;
			`LGL_OFS_CTRL: rdata_d[`LGL_CTRL_SW_BLANK] = sw_blank_q;
			`LGL_OFS_INFO: rdata_d[`LGL_INFO_REF_SHORT] = pins_s.ref_short;
			`LGL_OFS_BRIGHT:
			begin
				rdata_d[6:0] = bright2_q;
				rdata_d[`LGL_BRIGHT_TIMING_RESET_BIT] = ctrl1_q.timing_reset_bit;
				rdata_d[`LGL_BRIGHT_FIRST_LSB +: 7] = ctrl1_q.global_brightness;
			end
			`LGL_OFS_COUNT: rdata_d[11:0] = cnt_q;
			default: rdata_d = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= `LGL_RESP_OKAY;
		end
		else if (ce)
		begin
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rdata_d;
				s_axi_rresp <= known_ofs(s_axi_araddr) ? `LGL_RESP_OKAY : `LGL_RESP_SLVERR;
			end
			else if (s_axi_rvalid && s_axi_rready)
			begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
			else if (!s_axi_rvalid)
				s_axi_arready <= 1'b1;
		end
	end

endmodule

/* File: test/lgl_ctrl_model.sv */
// Purpose: display controller driving the link pins
// Assumes: pins change just after aclk edges
// Notes: half period H aclk cycles
`timescale 1ns/1ns
module lgl_ctrl_model
#(
	parameter int H = 4
)
(
	input wire logic aclk,
	output logic serial_in,
	output logic shift_clock,
	output logic latch_strobe,
	output logic pwm_ref_clock,
	output logic output_blank,
	output logic ref_current_short
);
	// ****************************************************************
	// pin driving
	// ****************************************************************
	initial
	begin
		serial_in = 1'b0;
		shift_clock = 1'b0;
		latch_strobe = 1'b0;
		pwm_ref_clock = 1'b0;
		output_blank = 1'b1;
		ref_current_short = 1'b0;
	end
	task tick(input int n);
		repeat (n) @(posedge aclk);
	endtask
	task load(input logic [192:0] v);
		for (int i = 192; i >= 0; i--)
		begin
			serial_in <= v[i];
			tick(H);
			shift_clock <= 1'b1;
			tick(H);
			shift_clock <= 1'b0;
		end
		serial_in <= ~v[0];
		tick(H);
		latch_strobe <= 1'b1;
		tick(H);
		latch_strobe <= 1'b0;
		tick(H);
	endtask
	task pwm(input int n);
		repeat (n)
		begin
			pwm_ref_clock <= 1'b1;
			tick(H);
			pwm_ref_clock <= 1'b0;
			tick(H);
		end
	endtask
	task pins(input logic b, input logic s);
		output_blank <= b;
		ref_current_short <= s;
		tick(8);
	endtask
endmodule

/* File: test/lgl_props.sv */
// Purpose: port checker for lgl_top
// Assumes: pins held >= 3 aclk, bound from the bench
// Notes: one clock domain
`timescale 1ns/1ns
module lgl_props
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic output_blank,
	input wire logic ref_current_short,
	input wire logic shift_clock,
	input wire logic serial_out,
	input wire logic [15:0] sink_output,
	input wire logic irq,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid
);
	// ****************************************************************
	// properties
	// ****************************************************************
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	AST_BLANK_OFF: assert property (output_blank [*6] |-> sink_output == 16'h0000)
		else $error("outputs on while blanked");
	AST_SHORT_OFF: assert property (ref_current_short [*6] |-> sink_output == 16'h0000)
		else $error("outputs on while reference shorted");
	AST_SHIFT_OUT: assert property ($changed(serial_out) |-> $past(shift_clock, 2) || $past(shift_clock, 3))
		else $error("serial out moved without shift clock");
	AST_WR_RESP: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
		else $error("write response late");
	AST_WR_BUSY: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write ready during response");
	AST_RD_RESP: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read response late");
	AST_RD_BUSY: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read ready during response");
	AST_IRQ_FALL: assert property ($fell(irq) |-> $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
		else $error("interrupt dropped without a write");
	cover property ($rose(irq));
	cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
	cover property ($changed(serial_out));
endmodule

/* File: test/lgl_top_test.sv */
// Purpose: register level tests of lgl_top
// Assumes: controller model drives the pins
// Notes: wstrb held constant, ce dropped once around a pwm burst
`timescale 1ns/1ns
`include "lgl_params.svh"
module lgl_top_test;
	logic aclk, aresetn, ce, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
	logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, serial_out, irq, serial_in, shift_clock, latch_strobe;
	logic pwm_ref_clock, output_blank, ref_current_short;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [15:0] sink_output;
	logic [192:0] w;
	int fails, samples_checked;
	lgl_top lgl_top_inst (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.serial_in(serial_in),
		.shift_clock(shift_clock),
		.latch_strobe(latch_strobe),
		.pwm_ref_clock(pwm_ref_clock),
		.output_blank(output_blank),
		.ref_current_short(ref_current_short),
		.serial_out(serial_out),
		.sink_output(sink_output),
		.irq(irq)
	);
	lgl_ctrl_model lgl_ctrl_model_inst (
		.aclk(aclk),
		.serial_in(serial_in),
		.shift_clock(shift_clock),
		.latch_strobe(latch_strobe),
		.pwm_ref_clock(pwm_ref_clock),
		.output_blank(output_blank),
		.ref_current_short(ref_current_short)
	);
	// ****************************************************************
	// helpers
	// ****************************************************************
	initial
	begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end
	task chk(input logic [33:0] got, input logic [33:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = `LGL_RESP_OKAY);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end
		while (!s_axi_bvalid);
		chk({32'h0, s_axi_bresp}, {32'h0, r});
		s_axi_bready <= 1'b0;
		@(posedge aclk);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = `LGL_RESP_OKAY);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end
		while (!s_axi_rvalid);
		chk({s_axi_rresp, s_axi_rdata}, {r, d});
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask
	task sink(input logic [15:0] e);
		repeat (8) @(posedge aclk);
		chk({18'h0, sink_output}, {18'h0, e});
	endtask
	task irqc(input logic e);
		chk({33'h0, irq}, {33'h0, e});
	endtask
	task give_verdict;
		$display("checks %0d errors %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// ****************************************************************
	// tests
	// ****************************************************************
	initial
	begin
		ce = 1'b1;
		aresetn = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		s_axi_awaddr = 8'h00;
		s_axi_araddr = 8'h00;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hF;
		fails = 0;
		samples_checked = 0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		for (int i = 0; i < 24; i += 4)
			rd(i[7:0], 32'h0);
		lgl_ctrl_model_inst.pins(1'b0, 1'b0);
		lgl_ctrl_model_inst.load({1'b1, 184'h0, 8'h85});
		rd(`LGL_OFS_BRIGHT, 32'h0005_0100);
		lgl_ctrl_model_inst.pwm(5);
		rd(`LGL_OFS_COUNT, 32'h5);
		sink(16'h0000);
		w = '0;
		for (int c = 0; c < 16; c++)
			w[c*12+:12] = c[11:0];
		lgl_ctrl_model_inst.load(w);
		rd(`LGL_OFS_COUNT, 32'h0);
		rd(`LGL_OFS_BRIGHT, 32'h0005_0105);
		sink(16'hFFFE);
		lgl_ctrl_model_inst.pwm(3);
		rd(`LGL_OFS_COUNT, 32'h3);
		sink(16'hFFF0);
		// pwm edges while frozen must not count
		ce <= 1'b0;
		lgl_ctrl_model_inst.pwm(2);
		ce <= 1'b1;
		rd(`LGL_OFS_COUNT, 32'h3);
		lgl_ctrl_model_inst.pins(1'b1, 1'b0);
		sink(16'h0000);
		rd(`LGL_OFS_COUNT, 32'h0);
		lgl_ctrl_model_inst.pins(1'b0, 1'b0);
		wr(`LGL_OFS_CTRL, 32'h1);
		sink(16'h0000);
		wr(`LGL_OFS_CTRL, 32'h0);
		sink(16'hFFFE);
		lgl_ctrl_model_inst.pins(1'b0, 1'b1);
		sink(16'h0000);
		rd(`LGL_OFS_INFO, 32'h1);
		lgl_ctrl_model_inst.pins(1'b0, 1'b0);
		lgl_ctrl_model_inst.pwm(2);
		lgl_ctrl_model_inst.load({1'b1, 192'h0});
		lgl_ctrl_model_inst.load({1'b0, {192{1'b1}}});
		rd(`LGL_OFS_COUNT, 32'h2);
		sink(16'hFFF8);
		rd(`LGL_OFS_BRIGHT, 32'h0000_0005);
		// counter wraps, second latch takes the first
		lgl_ctrl_model_inst.pwm(4094);
		rd(`LGL_OFS_COUNT, 32'h0);
		sink(16'hFFFF);
		rd(`LGL_OFS_STATUS, 32'hF);
		wr(`LGL_OFS_MASK, 32'h4);
		irqc(1'b1);
		wr(`LGL_OFS_STATUS, 32'h4);
		irqc(1'b0);
		rd(`LGL_OFS_STATUS, 32'hB);
		wr(`LGL_OFS_MASK, 32'h3);
		irqc(1'b1);
		wr(`LGL_OFS_STATUS, 32'hF);
		irqc(1'b0);
		rd(`LGL_OFS_STATUS, 32'h0);
		wr(8'h40, 32'h1, `LGL_RESP_SLVERR);
		rd(8'h40, 32'h0, `LGL_RESP_SLVERR);
		give_verdict();
	end
	initial
	begin
		repeat (60000) @(posedge aclk);
		fails++;
		give_verdict();
	end
endmodule
bind lgl_top lgl_props lgl_props_inst (
	.aclk(aclk),
	.aresetn(aresetn),
	.output_blank(output_blank),
	.ref_current_short(ref_current_short),
	.shift_clock(shift_clock),
	.serial_out(serial_out),
	.sink_output(sink_output),
	.irq(irq),
	.s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid),
	.s_axi_bresp(s_axi_bresp),
	.s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid)
);
